// ===== rtl/lwpp_regs.svh
`ifndef LWPP_REGS_SVH
`define LWPP_REGS_SVH

// register indices; byte address on the bus is four times the index
`define LWPP_IDX_PAGE 12'h008
`define LWPP_IDX_SOFT_ON 12'h582
`define LWPP_IDX_THR_LO 12'h583
`define LWPP_IDX_THR_HI 12'h584
`define LWPP_IDX_CTRL 12'h585
`define LWPP_IDX_RES_LO 12'h586
`define LWPP_IDX_RES_HI 12'h587
`define LWPP_IDX_IRQ_STAT 12'h5f0
`define LWPP_IDX_IRQ_EN 12'h5f1
`define LWPP_IDX_IRQ_CLR 12'h5f2
`define LWPP_IDX_INTERP 12'h5f3

// field positions
`define LWPP_FORCE_BIT 7
`define LWPP_LEVEL_BIT 6
`define LWPP_ENABLE_BIT 7
`define LWPP_CODE_MSB 3
`define LWPP_HI_MSB 4
`define LWPP_MAIN_MSB 3
`define LWPP_CHAN_LSB 4
`define LWPP_CHAN_MSB 7

// reset values
`define LWPP_SOFT_ON_RST 8'h40
`define LWPP_CTRL_RST 8'h00
`define LWPP_THR_RST 13'h0000
`define LWPP_INTERP_RST 8'h11
`define LWPP_PAGE_RST 8'h01

// timing counts and kept sample bits
`define LWPP_PM_MULT_BOTH 4
`define LWPP_PM_MULT_CHAN1 8
`define LWPP_PM_FIXED 32
`define LWPP_WIN_BASE_EXP 9
`define LWPP_CODE_MAX 10
`define LWPP_MSB_KEEP 6

`endif

// ===== rtl/lwpp_pkg.sv
`default_nettype none
package lwpp_pkg;

  // one converter's complex sample
  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } lwpp_sample_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [13:0] addr;
    logic [31:0] wdata;
  } lwpp_apb_req_t;

endpackage : lwpp_pkg
`default_nettype wire

// ===== rtl/lwpp_top.sv
// Added by the designer: the APB interface to the registers.
`include "lwpp_regs.svh"
`default_nettype none
module lwpp_top #(
  parameter int NUM_CONV = 2,
  parameter int WIN_BASE_EXP = `LWPP_WIN_BASE_EXP
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [13:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire lwpp_pkg::lwpp_sample_t [NUM_CONV-1:0] sample_i,
  input wire logic [NUM_CONV-1:0] gain_zero_i,
  output logic [NUM_CONV-1:0] soft_on_start_o,
  output logic [NUM_CONV-1:0] power_error_o,
  output logic irq_o
);

  localparam int BW = (NUM_CONV > 1) ? $clog2(NUM_CONV) : 1;
  localparam int SW = 2 * NUM_CONV;

  lwpp_pkg::lwpp_apb_req_t req;
  assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i, addr: paddr_i, wdata: pwdata_i};

  // ---------------- apb slave ----------------
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;

  wire apb_access = req.sel & req.enable;
  wire apb_first = apb_access & ~pready_ff;
  wire apb_done = apb_access & pready_ff;
  wire wr_en = apb_done & req.write;
  wire [11:0] idx = req.addr[13:2];

  wire hit_page = idx == `LWPP_IDX_PAGE;
  wire hit_soft_on = idx == `LWPP_IDX_SOFT_ON;
  wire hit_thr_lo = idx == `LWPP_IDX_THR_LO;
  wire hit_thr_hi = idx == `LWPP_IDX_THR_HI;
  wire hit_ctrl = idx == `LWPP_IDX_CTRL;
  wire hit_res_lo = idx == `LWPP_IDX_RES_LO;
  wire hit_res_hi = idx == `LWPP_IDX_RES_HI;
  wire hit_stat = idx == `LWPP_IDX_IRQ_STAT;
  wire hit_en = idx == `LWPP_IDX_IRQ_EN;
  wire hit_clr = idx == `LWPP_IDX_IRQ_CLR;
  wire hit_interp = idx == `LWPP_IDX_INTERP;
  wire addr_ok = hit_page | hit_soft_on | hit_thr_lo | hit_thr_hi | hit_ctrl | hit_res_lo | hit_res_hi |
                 hit_stat | hit_en | hit_clr | hit_interp;

  // one wait state: pready rises the cycle after the first access cycle, on the same edge that loads the read data
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= apb_first;
      pslverr_ff <= apb_first & ~addr_ok;
    end
  end

  // ---------------- global registers ----------------
  logic [7:0] page_ff;
  logic [7:0] interp_ff;
  logic [SW-1:0] irq_en_ff;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      page_ff <= `LWPP_PAGE_RST;
      interp_ff <= `LWPP_INTERP_RST;
      irq_en_ff <= '0;
    end else if (wr_en) begin
      if (hit_page) page_ff <= req.wdata[7:0];
      if (hit_interp) interp_ff <= req.wdata[7:0];
      if (hit_en) irq_en_ff <= req.wdata[SW-1:0];
    end
  end

  // reads come from the lowest selected bank when several pages are selected for a broadcast write
  function automatic logic [BW-1:0] first_bank(input logic [7:0] mask);
    first_bank = '0;
    for (int k = NUM_CONV - 1; k >= 0; k--) begin
      if (mask[k]) first_bank = BW'(k);
    end
  endfunction

  wire [BW-1:0] rd_bank = first_bank(page_ff);

  // ---------------- power-monitor clock enable ----------------
  wire [3:0] main_ratio = interp_ff[`LWPP_MAIN_MSB:0];
  wire [3:0] chan_ratio = interp_ff[`LWPP_CHAN_MSB:`LWPP_CHAN_LSB];
  wire main_gt1 = main_ratio > 4'h1;
  wire [7:0] pm_both = 8'(main_ratio * `LWPP_PM_MULT_BOTH);
  wire [7:0] pm_chan1 = 8'(main_ratio * `LWPP_PM_MULT_CHAN1);
  wire [7:0] pm_period = (main_gt1 && chan_ratio > 4'h1) ? pm_both :
                         (main_gt1 && chan_ratio == 4'h1) ? pm_chan1 :
                         8'(`LWPP_PM_FIXED);

  logic [7:0] pm_cnt_ff;
  logic pm_tick_ff;
  wire pm_wrap = pm_cnt_ff >= pm_period - 8'h01;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pm_cnt_ff <= '0;
      pm_tick_ff <= 1'b0;
    end else begin
      pm_cnt_ff <= pm_wrap ? 8'h00 : pm_cnt_ff + 8'h01;
      pm_tick_ff <= pm_wrap;
    end
  end

  // ---------------- per-converter banks ----------------
  logic [7:0] soft_on_ff [NUM_CONV];
  logic [12:0] thr_ff [NUM_CONV];
  logic mon_en_ff [NUM_CONV];
  logic [3:0] code_ff [NUM_CONV];
  logic [12:0] result_ff [NUM_CONV];
  logic [NUM_CONV-1:0] err_ff;
  logic [NUM_CONV-1:0] start_ff;
  logic [NUM_CONV-1:0] err_evt;

  genvar g;
  generate
    for (g = 0; g < NUM_CONV; g++) begin : g_bank
      logic [31:0] acc_ff;
      logic [31:0] win_ff;

      wire bank_wr = wr_en & page_ff[g];
      wire signed [5:0] i_top = sample_i[g].i[15 -: `LWPP_MSB_KEEP];
      wire signed [5:0] q_top = sample_i[g].q[15 -: `LWPP_MSB_KEEP];
      wire [11:0] i_sq = 12'(i_top * i_top);
      wire [11:0] q_sq = 12'(q_top * q_top);
      wire [12:0] inst_pwr = {1'b0, i_sq} + {1'b0, q_sq};
      // out-of-range codes are clamped so the accumulator cannot overflow
      wire [3:0] code_eff = (code_ff[g] > 4'(`LWPP_CODE_MAX)) ? 4'(`LWPP_CODE_MAX) : code_ff[g];
      wire [4:0] shift = 5'(WIN_BASE_EXP) + {1'b0, code_eff};
      wire [31:0] win_last_cnt = (32'h1 << shift) - 32'h1;
      wire win_last = win_ff >= win_last_cnt;
      wire [31:0] acc_sum = acc_ff + {19'h0, inst_pwr};
      wire [12:0] avg = 13'(acc_sum >> shift);
      wire over = avg > thr_ff[g];
      wire win_end = pm_tick_ff & mon_en_ff[g] & win_last;
      wire force_go = bank_wr & hit_soft_on & req.wdata[`LWPP_FORCE_BIT] & gain_zero_i[g];
      wire level_go = win_end & ~over & soft_on_ff[g][`LWPP_LEVEL_BIT] & gain_zero_i[g];

      assign err_evt[g] = win_end & over;

      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          soft_on_ff[g] <= `LWPP_SOFT_ON_RST;
          thr_ff[g] <= `LWPP_THR_RST;
          mon_en_ff[g] <= 1'b0;
          code_ff[g] <= '0;
        end else if (bank_wr) begin
          if (hit_soft_on) soft_on_ff[g] <= req.wdata[7:0];
          if (hit_thr_lo) thr_ff[g][7:0] <= req.wdata[7:0];
          if (hit_thr_hi) thr_ff[g][12:8] <= req.wdata[`LWPP_HI_MSB:0];
          if (hit_ctrl) begin
            mon_en_ff[g] <= req.wdata[`LWPP_ENABLE_BIT];
            code_ff[g] <= req.wdata[`LWPP_CODE_MSB:0];
          end
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
          acc_ff <= '0;
          win_ff <= '0;
          result_ff[g] <= '0;
          err_ff[g] <= 1'b0;
        end else if (!mon_en_ff[g]) begin
          // disabled: window restarts from scratch, last result stays readable
          acc_ff <= '0;
          win_ff <= '0;
          err_ff[g] <= 1'b0;
        end else if (pm_tick_ff) begin
          if (win_last) begin
            acc_ff <= '0;
            win_ff <= '0;
            result_ff[g] <= avg;
            err_ff[g] <= over;
          end else begin
            acc_ff <= acc_sum;
            win_ff <= win_ff + 32'h1;
          end
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) start_ff[g] <= 1'b0;
        else start_ff[g] <= force_go | level_go;
      end
    end
  endgenerate

  // ---------------- interrupts ----------------
  logic [SW-1:0] irq_stat_ff;
  logic irq_ff;
  wire [SW-1:0] irq_evt = {start_ff, err_evt};
  wire [SW-1:0] irq_clr = (wr_en & hit_clr) ? req.wdata[SW-1:0] : '0;
  // a new event in the clearing cycle survives the clear
  wire [SW-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_en_ff);
    end
  end

  // ---------------- read data ----------------
  wire [7:0] rd_soft_on = soft_on_ff[rd_bank];
  wire [7:0] rd_thr_lo = thr_ff[rd_bank][7:0];
  wire [7:0] rd_thr_hi = {3'h0, thr_ff[rd_bank][12:8]};
  wire [7:0] rd_ctrl = {mon_en_ff[rd_bank], 3'h0, code_ff[rd_bank]};
  wire [7:0] rd_res_lo = result_ff[rd_bank][7:0];
  wire [7:0] rd_res_hi = {3'h0, result_ff[rd_bank][12:8]};
  wire [31:0] rd_data = hit_page ? {24'h0, page_ff} :
                        hit_soft_on ? {24'h0, rd_soft_on} :
                        hit_thr_lo ? {24'h0, rd_thr_lo} :
                        hit_thr_hi ? {24'h0, rd_thr_hi} :
                        hit_ctrl ? {24'h0, rd_ctrl} :
                        hit_res_lo ? {24'h0, rd_res_lo} :
                        hit_res_hi ? {24'h0, rd_res_hi} :
                        hit_stat ? 32'(irq_stat_ff) :
                        hit_en ? 32'(irq_en_ff) :
                        hit_interp ? {24'h0, interp_ff} : 32'h0;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) prdata_ff <= '0;
    else if (apb_first && !req.write) prdata_ff <= rd_data;
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign soft_on_start_o = start_ff;
  assign power_error_o = err_ff;
  assign irq_o = irq_ff;

endmodule : lwpp_top
`default_nettype wire

// ===== sim/lwpp_assertions.sv
`include "lwpp_regs.svh"
`default_nettype none
module lwpp_assertions #(
  parameter int NUM_CONV = 2
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [13:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [NUM_CONV-1:0] gain_zero_i,
  input wire logic [NUM_CONV-1:0] soft_on_start_o
);
  wire logic [11:0] idx = paddr_i[13:2];
  wire logic mapped = idx inside {`LWPP_IDX_PAGE, [`LWPP_IDX_SOFT_ON:`LWPP_IDX_RES_HI],
                                  [`LWPP_IDX_IRQ_STAT:`LWPP_IDX_INTERP]};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_acc;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_rd(logic [11:0] a);
    s_acc ##0 (!pwrite_i && idx == a);
  endsequence
  property p_ans; s_acc |=> pready_o ##1 !pready_o; endproperty
  a_ans: assert property (p_ans) else $error("ready not a single cycle");
  property p_map; s_acc |=> pslverr_o == !$past(mapped); endproperty
  a_map: assert property (p_map) else $error("error flag wrong for index");
  property p_cause; $rose(pready_o) |-> $past(psel_i && penable_i); endproperty
  a_cause: assert property (p_cause) else $error("ready without access");
  property p_res; s_rd(`LWPP_IDX_RES_HI) |=> prdata_o[31:5] == 27'h0; endproperty
  a_res: assert property (p_res) else $error("result high wider than five bits");
  property p_thr; s_rd(`LWPP_IDX_THR_HI) |=> prdata_o[31:5] == 27'h0; endproperty
  a_thr: assert property (p_thr) else $error("threshold high wider than five bits");
  property p_clr; s_rd(`LWPP_IDX_IRQ_CLR) |=> prdata_o == 32'h0; endproperty
  a_clr: assert property (p_clr) else $error("clear register read not zero");
  property p_pulse; soft_on_start_o[0] |=> !soft_on_start_o[0]; endproperty
  a_pulse: assert property (p_pulse) else $error("soft-on start longer than one cycle");
  // force and level starts both need the gain at zero shortly before
  property p_gain; $rose(soft_on_start_o[0]) |-> $past(gain_zero_i[0]) || $past(gain_zero_i[0], 2); endproperty
  a_gain: assert property (p_gain) else $error("soft-on start with gain not zero");
endmodule // lwpp_assertions
bind lwpp_top lwpp_assertions #(.NUM_CONV(NUM_CONV)) u_chk (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .gain_zero_i(gain_zero_i), .soft_on_start_o(soft_on_start_o));
`default_nettype wire

// ===== sim/tb_lwpp_top.sv
`include "lwpp_regs.svh"
`default_nettype none
module tb_lwpp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, sel = 1'b0, en = 1'b0, wr = 1'b0, rdy, err, irq, le;
  logic [13:0] addr = '0;
  logic [31:0] wd = '0, rd, r;
  lwpp_pkg::lwpp_sample_t [1:0] smp = '0;
  logic [1:0] gz = '0, son, perr;
  int n_mismatch = 0, comparisons = 0, cyc = 0, on0 = 0, on1 = 0, n;
  // cycle stamps of the last two soft-on pulses of bank 1, and its pulse count before a window run
  int t0 = 0, t1 = 0, m = 0;
  // interp setting, code and the period each setting implies
  localparam logic [7:0] IP [4] = '{8'h11, 8'h22, 8'h13, 8'h21};
  localparam logic [3:0] CD [4] = '{4'h0, 4'h1, 4'h0, 4'h2};
  localparam int PP [4] = '{32, 8, 24, 32};
  lwpp_top #(.NUM_CONV(2), .WIN_BASE_EXP(1)) DUT (.sys_clk_i(clk), .sys_rst_i(rst), .psel_i(sel),
    .penable_i(en), .pwrite_i(wr), .paddr_i(addr), .pwdata_i(wd), .prdata_o(rd), .pready_o(rdy),
    .pslverr_o(err), .sample_i(smp), .gain_zero_i(gz), .soft_on_start_o(son), .power_error_o(perr),
    .irq_o(irq));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (son[0] === 1'b1) on0++;
    if (son[1] === 1'b1) begin
      on1++;
      t0 = t1;
      t1 = cyc;
    end
    if (cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, x);
    comparisons++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one idle edge after release so the next setup never lands in the same step
  task automatic acc(input logic w, input logic [11:0] i, input logic [31:0] v);
    sel <= 1'b1;
    wr <= w;
    addr <= {i, 2'b00};
    wd <= v;
    @(posedge clk);
    en <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    r = rd;
    le = err;
    sel <= 1'b0;
    en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wa(input logic [11:0] i, input logic [31:0] v);
    acc(1'b1, i, v);
  endtask
  task automatic rc(input logic [11:0] i, input logic [31:0] x);
    acc(1'b0, i, 32'h0);
    chk(r, x);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(`LWPP_IDX_PAGE, 32'h1);
    rc(`LWPP_IDX_SOFT_ON, 32'h40);
    rc(`LWPP_IDX_THR_LO, 32'h0);
    rc(`LWPP_IDX_CTRL, 32'h0);
    rc(`LWPP_IDX_RES_HI, 32'h0);
    rc(12'h100, 32'h0);
    chk(le, 1'b1);
    wa(`LWPP_IDX_THR_HI, 32'hff);
    rc(`LWPP_IDX_THR_HI, 32'h1f);
    wa(`LWPP_IDX_RES_LO, 32'hff);
    rc(`LWPP_IDX_RES_LO, 32'h0);
    wa(`LWPP_IDX_THR_HI, 32'h0);
    $display("test registers done");
    wa(`LWPP_IDX_SOFT_ON, 32'hc0);
    @(posedge clk);
    chk(on0, 0);
    gz <= 2'b11;
    wa(`LWPP_IDX_SOFT_ON, 32'hc0);
    @(posedge clk);
    chk(on0, 1);
    chk(on1, 0);
    rc(`LWPP_IDX_IRQ_STAT, 32'h4);
    chk(irq, 1'b0);
    wa(`LWPP_IDX_IRQ_EN, 32'h4);
    @(posedge clk);
    chk(irq, 1'b1);
    wa(`LWPP_IDX_IRQ_CLR, 32'h4);
    @(posedge clk);
    chk(irq, 1'b0);
    rc(`LWPP_IDX_IRQ_CLR, 32'h0);
    $display("test soft-on done");
    // bank 1 stays under its limit so its level soft-on pulses time the window exactly
    wa(`LWPP_IDX_PAGE, 32'h2);
    wa(`LWPP_IDX_THR_LO, 32'hff);
    wa(`LWPP_IDX_PAGE, 32'h3);
    smp <= {16'h2000, 16'h0, 16'h4000, 16'hc000};
    for (int k = 0; k < 4; k++) begin
      wa(`LWPP_IDX_INTERP, {24'h0, IP[k]});
      m = on1;
      wa(`LWPP_IDX_CTRL, {28'h8, CD[k]});
      n = 0;
      while (perr[0] !== 1'b1) begin
        @(posedge clk);
        n++;
      end
      // the tick divider runs free, so the first tick after enable comes 1 to P cycles later
      n = n - (2 ** (1 + CD[k])) * PP[k];
      chk(n > -PP[k] && n <= 0, 1);
      while (on1 < m + 2) @(posedge clk);
      chk(t1 - t0, (2 ** (1 + CD[k])) * PP[k]);
      wa(`LWPP_IDX_CTRL, 32'h0);
      @(posedge clk);
      chk(perr[0], 1'b0);
    end
    $display("test window done");
    wa(`LWPP_IDX_THR_LO, 32'hff);
    wa(`LWPP_IDX_PAGE, 32'h2);
    wa(`LWPP_IDX_THR_LO, 32'h40);
    wa(`LWPP_IDX_PAGE, 32'h3);
    n = on1;
    wa(`LWPP_IDX_CTRL, 32'h80);
    while (perr[0] !== 1'b1) @(posedge clk);
    repeat (3) @(posedge clk);
    chk(perr, 2'b01);
    chk(on1 > n, 1);
    rc(`LWPP_IDX_RES_LO, 32'h0);
    rc(`LWPP_IDX_RES_HI, 32'h2);
    wa(`LWPP_IDX_PAGE, 32'h2);
    rc(`LWPP_IDX_RES_LO, 32'h40);
    $display("test level done");
    results();
  end
endmodule // tb_lwpp_top
`default_nettype wire
